// [hdl/otd_pkg.sv]
// constants for the option and trim byte decoder
// assumes a byte-wide on-chip flash port and a 32-bit APB slave port
package otd_pkg;

	// ----------------------------------------------------------------
	// flash map
	// ----------------------------------------------------------------
	localparam int FLASH_AW = 13;
	localparam logic [12:0] FL_OPT0_ADDR = 13'h0000; // program memory
	localparam logic [12:0] FL_OPT1_ADDR = 13'h0001; // program memory
	localparam logic [12:0] FL_TRIM_BASE = 13'h0020; // information page
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// trim area indices
	localparam logic [7:0] TRIM_IDX_ADC_REF = 8'h00;
	localparam logic [7:0] TRIM_IDX_ADC_CMP = 8'h01;
	localparam logic [7:0] TRIM_IDX_IPO = 8'h02;
	localparam logic [7:0] TRIM_IDX_OSC_BO = 8'h03;
	localparam logic [7:0] TRIM_IDX_CLK_FILT = 8'h06;

	// ----------------------------------------------------------------
	// register indices and byte addresses
	// ----------------------------------------------------------------
	localparam logic [11:0] IDX_OPT0 = 12'h000;
	localparam logic [11:0] IDX_OPT1 = 12'h001;
	localparam logic [11:0] IDX_TRIM = 12'h020;
	localparam logic [11:0] IDX_STATUS = 12'h040;
	localparam logic [11:0] ADDR_OPT0 = 12'(IDX_OPT0 * 4);
	localparam logic [11:0] ADDR_OPT1 = 12'(IDX_OPT1 * 4);
	localparam logic [11:0] ADDR_TRIM = 12'(IDX_TRIM * 4);
	localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int B0_WDT_RESET_SEL = 7;
	localparam int B0_WDT_ALWAYS_ON = 6;
	localparam int B0_OSC_MODE_HI = 5;
	localparam int B0_OSC_MODE_LO = 4;
	localparam int B0_BO_ALWAYS_ON = 3;
	localparam int B0_READ_PROT = 2;
	localparam int B0_WRITE_PROT = 0;
	localparam int B1_BO_RESET_SEL = 7;
	localparam int B1_XTAL_OFF = 4;
	localparam int TRIM_REF_HI = 7;
	localparam int TRIM_REF_LO = 3;
	localparam int ST_CFG_VALID = 0;
	localparam int ST_PROG_BLOCKED = 1;
	localparam int ST_WDT_RUN = 2;

	// fetch sequence: option byte 0, option byte 1, reference trim
	localparam logic [1:0] FETCH_LAST = 2'h2;

	// ----------------------------------------------------------------
	// controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OTD_FETCH = 4'h1,
		OTD_WAIT = 4'h2,
		OTD_IDLE = 4'h4,
		OTD_WRITE = 4'h8
	} otd_state_t;

endpackage

// [hdl/otd_sync.sv]
// two-stage synchroniser for asynchronous event levels
// assumes inputs come from another clock or an analog detector
`timescale 1ns/1ps
`default_nettype none

module otd_sync
	import otd_pkg::*;
#(
	parameter int WIDTH = 2
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ----------------------------------------------------------------
	// one synchroniser per bit
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic meta_r;
			logic stable_r;
			// first stage feeds only the second
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_r <= 1'b0;
					stable_r <= 1'b0;
				end
				else
				begin
					meta_r <= async_in[i];
					stable_r <= meta_r;
				end
			end
			assign sync_out[i] = stable_r;
		end
	endgenerate

endmodule
`default_nettype wire

// [hdl/otd_decoder.sv]
// option and trim byte decoder: fetches option bytes and trim at reset
// assumes a same-clock flash port (req held until one-cycle ack) and APB
//
// Summary of operation
// - first two program bytes hold options; configuration derives from them
// - byte zero: wdt reset, wdt on, osc mode, bo on, read, -, write protect
// - option bytes unchanged by reset, readable and writable as memory
// - wdt reset select zero: time-out raises an interrupt request
// - wdt reset select one (erased): time-out requests a system reset
// - wdt always-on zero: watchdog runs from power-up, cannot be stopped
// - wdt always-on one: watchdog starts on instruction, stops only on reset
// - brown-out reset select one: brown-out event requests a system reset
// - crystal-off bit zero runs crystal during reset; one keeps it off
// - trim index 00h ref, 01h adc/cmp, 02h ipo, 03h osc/bo, 06h filter
// - reference trim at info page 0020h, upper bits value, kept over reset
// - write protect one allows programming; both protect bits zero block it
`timescale 1ns/1ps
`default_nettype none

module otd_decoder
	import otd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic flash_req,
	output logic flash_we,
	output logic flash_info,
	output logic [FLASH_AW-1:0] flash_addr,
	output logic [7:0] flash_wdata,
	input wire logic flash_ack,
	input wire logic [7:0] flash_rdata,
	input wire logic watchdog_timeout,
	input wire logic brownout_detect,
	input wire logic watchdog_instr,
	output logic config_valid,
	output logic watchdog_reset_select,
	output logic watchdog_always_on,
	output logic [1:0] oscillator_mode_select,
	output logic brownout_always_on,
	output logic read_protect,
	output logic write_protect,
	output logic brownout_reset_select,
	output logic crystal_run_in_reset,
	output logic [TRIM_REF_HI-TRIM_REF_LO:0] adc_reference_trim_value,
	output logic watchdog_run,
	output logic watchdog_irq,
	output logic system_reset_req
);

	// ----------------------------------------------------------------
	// state record
	// ----------------------------------------------------------------
	typedef struct packed {
		otd_state_t state;
		logic [1:0] idx;
		logic [7:0] opt0_img;
		logic [7:0] opt1_img;
		logic [7:0] trim_img;
		logic [7:0] opt0_cfg;
		logic [7:0] opt1_cfg;
		logic [7:0] trim_cfg;
		logic cfg_valid;
		logic fl_req;
		logic fl_we;
		logic fl_info;
		logic [FLASH_AW-1:0] fl_addr;
		logic [7:0] fl_wdata;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [1:0] evt_prev;
		logic wdt_irq;
		logic sys_rst;
		logic wdt_run;
	} otd_regs_t;

	otd_regs_t s_r;
	otd_regs_t s_nxt;
	logic [1:0] evt_sync;
	logic [1:0] evt_rise;
	logic prog_blocked;
	logic apb_start;

	// ----------------------------------------------------------------
	// event synchronisers (watchdog time-out, brown-out)
	// ----------------------------------------------------------------
	otd_sync #(.WIDTH(2)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({brownout_detect, watchdog_timeout}),
		.sync_out(evt_sync)
	);

	assign evt_rise = evt_sync & ~s_r.evt_prev;
	// both protect bits low locks out user programming
	assign prog_blocked = !s_r.opt0_cfg[B0_WRITE_PROT] && !s_r.opt0_cfg[B0_READ_PROT];
	assign apb_start = psel && penable && !s_r.pready;

	// fetch address for each step of the reset sequence
	function automatic logic [FLASH_AW-1:0] fetch_addr(input logic [1:0] i);
		case (i)
			2'h0: fetch_addr = FL_OPT0_ADDR;
			2'h1: fetch_addr = FL_OPT1_ADDR;
			default: fetch_addr = FL_TRIM_BASE + {5'h00, TRIM_IDX_ADC_REF};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.wdt_irq = 1'b0;
		s_nxt.sys_rst = 1'b0;
		s_nxt.evt_prev = evt_sync;
		case (s_r.state)
			// issue one fetch read
			OTD_FETCH:
			begin
				s_nxt.fl_req = 1'b1;
				s_nxt.fl_we = 1'b0;
				s_nxt.fl_info = (s_r.idx == FETCH_LAST);
				s_nxt.fl_addr = fetch_addr(s_r.idx);
				s_nxt.state = OTD_WAIT;
			end
			// capture fetched byte into image and held config
			OTD_WAIT:
			begin
				if (flash_ack)
				begin
					s_nxt.fl_req = 1'b0;
					case (s_r.idx)
						2'h0:
						begin
							s_nxt.opt0_img = flash_rdata;
							s_nxt.opt0_cfg = flash_rdata;
						end
						2'h1:
						begin
							s_nxt.opt1_img = flash_rdata;
							s_nxt.opt1_cfg = flash_rdata;
						end
						default:
						begin
							s_nxt.trim_img = flash_rdata;
							s_nxt.trim_cfg = flash_rdata;
						end
					endcase
					if (s_r.idx == FETCH_LAST)
					begin
						s_nxt.cfg_valid = 1'b1;
						s_nxt.state = OTD_IDLE;
					end
					else
					begin
						s_nxt.idx = s_r.idx + 2'h1;
						s_nxt.state = OTD_FETCH;
					end
				end
			end
			// serve register accesses
			OTD_IDLE:
			begin
				if (apb_start)
				begin
					s_nxt.prdata = 32'h0000_0000;
					s_nxt.pready = 1'b1;
					case (paddr)
						ADDR_OPT0: s_nxt.prdata = {24'h00_0000, s_r.opt0_img};
						ADDR_OPT1: s_nxt.prdata = {24'h00_0000, s_r.opt1_img};
						ADDR_TRIM: s_nxt.prdata = {24'h00_0000, s_r.trim_img};
						ADDR_STATUS:
						begin
							s_nxt.prdata[ST_CFG_VALID] = s_r.cfg_valid;
							s_nxt.prdata[ST_PROG_BLOCKED] = prog_blocked;
							s_nxt.prdata[ST_WDT_RUN] = s_r.wdt_run;
						end
						default: s_nxt.pslverr = 1'b1;
					endcase
					if (pwrite)
					begin
						if (paddr == ADDR_OPT0 || paddr == ADDR_OPT1 || paddr == ADDR_TRIM)
						begin
							if (prog_blocked)
							begin
								s_nxt.pslverr = 1'b1;
							end
							else
							begin
								// program the byte; held config stays as fetched
								s_nxt.pready = 1'b0;
								s_nxt.fl_req = 1'b1;
								s_nxt.fl_we = 1'b1;
								s_nxt.fl_info = (paddr == ADDR_TRIM);
								s_nxt.fl_wdata = pwdata[7:0];
								s_nxt.fl_addr = (paddr == ADDR_OPT0) ? FL_OPT0_ADDR :
									(paddr == ADDR_OPT1) ? FL_OPT1_ADDR : FL_TRIM_BASE;
								s_nxt.state = OTD_WRITE;
							end
						end
						else
						begin
							s_nxt.pslverr = 1'b1; // status is read-only
						end
					end
				end
			end
			// wait for the flash to take the byte
			OTD_WRITE:
			begin
				if (flash_ack)
				begin
					s_nxt.fl_req = 1'b0;
					s_nxt.fl_we = 1'b0;
					s_nxt.pready = 1'b1;
					case ({s_r.fl_info, s_r.fl_addr[0]})
						2'b00: s_nxt.opt0_img = s_r.fl_wdata;
						2'b01: s_nxt.opt1_img = s_r.fl_wdata;
						default: s_nxt.trim_img = s_r.fl_wdata;
					endcase
					s_nxt.state = OTD_IDLE;
				end
			end
			default: s_nxt.state = OTD_FETCH;
		endcase
		// watchdog time-out routing
		if (s_r.cfg_valid && evt_rise[0])
		begin
			if (s_r.opt0_cfg[B0_WDT_RESET_SEL])
			begin
				s_nxt.sys_rst = 1'b1;
			end
			else
			begin
				s_nxt.wdt_irq = 1'b1;
			end
		end
		// brown-out routing
		if (s_r.cfg_valid && evt_rise[1] && s_r.opt1_cfg[B1_BO_RESET_SEL])
		begin
			s_nxt.sys_rst = 1'b1;
		end
		// watchdog enable: only reset clears it
		if (s_r.cfg_valid && !s_r.opt0_cfg[B0_WDT_ALWAYS_ON])
		begin
			s_nxt.wdt_run = 1'b1;
		end
		if (s_r.cfg_valid && s_r.opt0_cfg[B0_WDT_ALWAYS_ON] && watchdog_instr)
		begin
			s_nxt.wdt_run = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// state register; config shows erased values until fetched
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r <= '0;
			s_r.state <= OTD_FETCH;
			s_r.opt0_cfg <= ERASED_BYTE;
			s_r.opt1_cfg <= ERASED_BYTE;
			s_r.trim_cfg <= ERASED_BYTE;
			s_r.opt0_img <= ERASED_BYTE;
			s_r.opt1_img <= ERASED_BYTE;
			s_r.trim_img <= ERASED_BYTE;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from the state record
	// ----------------------------------------------------------------
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign flash_req = s_r.fl_req;
	assign flash_we = s_r.fl_we;
	assign flash_info = s_r.fl_info;
	assign flash_addr = s_r.fl_addr;
	assign flash_wdata = s_r.fl_wdata;
	assign config_valid = s_r.cfg_valid;
	assign watchdog_reset_select = s_r.opt0_cfg[B0_WDT_RESET_SEL];
	assign watchdog_always_on = s_r.opt0_cfg[B0_WDT_ALWAYS_ON];
	assign oscillator_mode_select = s_r.opt0_cfg[B0_OSC_MODE_HI:B0_OSC_MODE_LO];
	assign brownout_always_on = s_r.opt0_cfg[B0_BO_ALWAYS_ON];
	assign read_protect = s_r.opt0_cfg[B0_READ_PROT];
	assign write_protect = s_r.opt0_cfg[B0_WRITE_PROT];
	assign brownout_reset_select = s_r.opt1_cfg[B1_BO_RESET_SEL];
	// enable only, never the clock source choice
	assign crystal_run_in_reset = !s_r.opt1_cfg[B1_XTAL_OFF];
	assign adc_reference_trim_value = s_r.trim_cfg[TRIM_REF_HI:TRIM_REF_LO];
	assign watchdog_run = s_r.wdt_run;
	assign watchdog_irq = s_r.wdt_irq;
	assign system_reset_req = s_r.sys_rst;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence seq_wdt_edge;
		s_r.cfg_valid && evt_rise[0];
	endsequence
	sequence seq_write_go;
		s_r.state == OTD_IDLE && apb_start && pwrite && paddr == ADDR_OPT0 && !prog_blocked;
	endsequence

	chk_wdt_irq_route: assert property (seq_wdt_edge ##0 !s_r.opt0_cfg[B0_WDT_RESET_SEL]
		|=> watchdog_irq && !system_reset_req) else $error("timeout irq missing");
	chk_wdt_rst_route: assert property (seq_wdt_edge ##0 s_r.opt0_cfg[B0_WDT_RESET_SEL]
		|=> system_reset_req && !watchdog_irq) else $error("timeout reset missing");
	chk_wdt_auto_on: assert property (config_valid && !watchdog_always_on
		|=> watchdog_run) else $error("watchdog not auto started");
	chk_wdt_stays_on: assert property (watchdog_run |=> watchdog_run)
		else $error("watchdog stopped without reset");
	chk_wdt_instr_start: assert property (config_valid && watchdog_always_on && !watchdog_run
		&& !watchdog_instr |=> !watchdog_run) else $error("watchdog started early");
	chk_bo_reset: assert property (s_r.cfg_valid && evt_rise[1] && brownout_reset_select
		|=> system_reset_req) else $error("brown-out reset missing");
	chk_xtal_enable: assert property (config_valid |=> $stable(crystal_run_in_reset))
		else $error("crystal enable moved");
	chk_cfg_stable: assert property (config_valid && s_r.state != OTD_WAIT
		|=> $stable(s_r.opt0_cfg) && $stable(s_r.opt1_cfg)) else $error("config moved");
	chk_fetch_done: assert property ($rose(config_valid) |-> $past(flash_ack)
		&& flash_addr == FL_TRIM_BASE) else $error("fetch order wrong");
	chk_block_prog: assert property (s_r.state == OTD_IDLE && apb_start && pwrite
		&& paddr == ADDR_OPT0 && prog_blocked |=> pslverr && !flash_req)
		else $error("blocked write reached flash");
	chk_write_issue: assert property (seq_write_go |=> flash_req && flash_we
		&& flash_addr == FL_OPT0_ADDR && config_valid)
		else $error("write not issued");

endmodule
`default_nettype wire

// [testbench/otd_flash_model.sv]
// byte-wide flash array model behind the decoder's fetch and program port
// assumes a same-clock req/ack handshake; the bench sets the answer latency
`timescale 1ns/1ps
`default_nettype none

module otd_flash_model
	import otd_pkg::*;
(
	input wire logic pclk,
	input wire logic flash_req,
	input wire logic flash_we,
	input wire logic flash_info,
	input wire logic [FLASH_AW-1:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	input wire logic [3:0] latency,
	output logic flash_ack,
	output logic [7:0] flash_rdata
);
	// information page in the upper half, program memory below
	logic [7:0] mem [0:16383];
	logic [3:0] wait_cnt;

	// ----------------------------------------------------------------
	// erased array, no reset: contents survive any reset
	// ----------------------------------------------------------------
	initial
	begin
		for (int i = 0; i < 16384; i++)
			mem[i] = ERASED_BYTE;
		flash_ack = 1'b0;
		flash_rdata = 8'h00;
		wait_cnt = 4'h0;
	end

	// ack after the set latency; data lines toggle outside an ack
	always @(posedge pclk)
	begin
		if (flash_ack || !flash_req)
		begin
			flash_ack <= 1'b0;
			wait_cnt <= 4'h0;
			flash_rdata <= ~flash_rdata;
		end
		else if (wait_cnt < latency)
		begin
			wait_cnt <= wait_cnt + 4'h1;
			flash_rdata <= ~flash_rdata;
		end
		else
		begin
			flash_ack <= 1'b1;
			if (flash_we)
				mem[{flash_info, flash_addr}] <= mem[{flash_info, flash_addr}] & flash_wdata;
			else
				flash_rdata <= mem[{flash_info, flash_addr}];
		end
	end
endmodule
`default_nettype wire

// [testbench/otd_decoder_tb_top.sv]
// self-checking bench for the option and trim byte decoder
// assumes otd_pkg and the flash model; apb master tasks drive the registers
`timescale 1ns/1ps
`default_nettype none

module otd_decoder_tb_top
	import otd_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic flash_req, flash_we, flash_info, flash_ack;
	logic [FLASH_AW-1:0] flash_addr;
	logic [7:0] flash_wdata, flash_rdata;
	logic [3:0] latency;
	logic watchdog_timeout, brownout_detect, watchdog_instr, config_valid;
	logic watchdog_reset_select, watchdog_always_on, brownout_always_on;
	logic read_protect, write_protect, brownout_reset_select, crystal_run_in_reset;
	logic [1:0] oscillator_mode_select;
	logic [4:0] adc_reference_trim_value;
	logic watchdog_run, watchdog_irq, system_reset_req;
	logic [31:0] rd;
	logic err;
	logic [13:0] fetch_q [$];
	int n_mismatch = 0;
	int checks_done = 0;
	int n_irq = 0;
	int n_rst = 0;

	// ----------------------------------------------------------------
	// design, flash partner, clock
	// ----------------------------------------------------------------
	otd_decoder dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_req(flash_req), .flash_we(flash_we),
		.flash_info(flash_info), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_ack(flash_ack), .flash_rdata(flash_rdata),
		.watchdog_timeout(watchdog_timeout), .brownout_detect(brownout_detect),
		.watchdog_instr(watchdog_instr), .config_valid(config_valid),
		.watchdog_reset_select(watchdog_reset_select),
		.watchdog_always_on(watchdog_always_on),
		.oscillator_mode_select(oscillator_mode_select),
		.brownout_always_on(brownout_always_on), .read_protect(read_protect),
		.write_protect(write_protect), .brownout_reset_select(brownout_reset_select),
		.crystal_run_in_reset(crystal_run_in_reset),
		.adc_reference_trim_value(adc_reference_trim_value), .watchdog_run(watchdog_run),
		.watchdog_irq(watchdog_irq), .system_reset_req(system_reset_req));

	otd_flash_model flash_u (.pclk(pclk), .flash_req(flash_req), .flash_we(flash_we),
		.flash_info(flash_info), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.latency(latency), .flash_ack(flash_ack), .flash_rdata(flash_rdata));

	always #5 pclk = ~pclk;

	// record fetch addresses and count event pulses
	always @(posedge pclk)
	begin
		if (flash_req === 1'b1 && flash_ack === 1'b1 && flash_we === 1'b0)
			fetch_q.push_back({flash_info, flash_addr});
		if (watchdog_irq === 1'b1)
			n_irq++;
		if (system_reset_req === 1'b1)
			n_rst++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [14:0] cfg_vec();
		return {watchdog_reset_select, watchdog_always_on, oscillator_mode_select,
			brownout_always_on, read_protect, write_protect, brownout_reset_select,
			crystal_run_in_reset, adc_reference_trim_value, config_valid};
	endfunction

	function automatic logic [14:0] exp_cfg(input logic [7:0] b0, input logic [7:0] b1,
		input logic [7:0] t, input logic cv);
		return {b0[7], b0[6], b0[5:4], b0[3], b0[2], b0[0], b1[7], ~b1[4], t[7:3], cv};
	endfunction

	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, waiting on pready under a bound
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
		input logic [31:0] exp_rd, input logic exp_err);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 300; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 300)
		begin
			n_mismatch++;
			wrap_up();
		end
		check({31'h0, err}, {31'h0, exp_err});
		if (!wr && !exp_err)
			check(rd, exp_rd);
	endtask

	// reset with erased outputs checked while it is held
	task automatic do_reset(input logic [3:0] lat);
		@(posedge pclk);
		presetn <= 1'b0;
		latency <= lat;
		repeat (10) @(posedge pclk);
		check(cfg_vec(), exp_cfg(8'hff, 8'hff, 8'hff, 1'b0));
		fetch_q.delete();
		presetn <= 1'b1;
	endtask

	// raise one event input and count pulses on both outputs
	task automatic ev_chk(input logic wdt, input int e_irq, input int e_rst);
		int b_irq;
		int b_rst;
		@(negedge pclk);
		b_irq = n_irq;
		b_rst = n_rst;
		@(posedge pclk);
		watchdog_timeout <= wdt;
		brownout_detect <= ~wdt;
		repeat (3) @(posedge pclk);
		watchdog_timeout <= 1'b0;
		brownout_detect <= 1'b0;
		repeat (8) @(negedge pclk);
		check(32'(n_irq - b_irq), 32'(e_irq));
		check(32'(n_rst - b_rst), 32'(e_rst));
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, watchdog_timeout, brownout_detect, watchdog_instr} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		latency = 4'h1;
		@(negedge pclk);
		flash_u.mem[0] = 8'h5a;
		flash_u.mem[1] = 8'h6f;
		flash_u.mem[14'h2020] = 8'hab;
		do_reset(4'h1);
		apb(1'b0, ADDR_OPT0, 32'h0, 32'h5a, 1'b0);
		check(32'(fetch_q.size()), 32'h3);
		check(fetch_q[0], 14'h0000);
		check(fetch_q[1], 14'h0001);
		check(fetch_q[2], 14'h2020);
		check(cfg_vec(), exp_cfg(8'h5a, 8'h6f, 8'hab, 1'b1));
		check(watchdog_run, 1'b0);
		apb(1'b0, ADDR_OPT1, 32'h0, 32'h6f, 1'b0);
		apb(1'b0, ADDR_TRIM, 32'h0, 32'hab, 1'b0);
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h3, 1'b0);
		apb(1'b1, ADDR_OPT0, 32'hffffff00, 32'h0, 1'b1);
		check(flash_u.mem[0], 8'h5a);
		apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'h7, 32'h0, 1'b1);
		ev_chk(1'b1, 1, 0);
		ev_chk(1'b0, 0, 0);
		@(posedge pclk);
		watchdog_instr <= 1'b1;
		@(posedge pclk);
		watchdog_instr <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h7, 1'b0);
		check(watchdog_run, 1'b1);
		// second configuration, slow flash, contents kept over reset
		flash_u.mem[0] = 8'hb9;
		flash_u.mem[1] = 8'hff;
		do_reset(4'h6);
		apb(1'b0, ADDR_TRIM, 32'h0, 32'hab, 1'b0);
		check(cfg_vec(), exp_cfg(8'hb9, 8'hff, 8'hab, 1'b1));
		check(watchdog_run, 1'b1);
		apb(1'b1, ADDR_OPT0, 32'hffffff99, 32'h0, 1'b0);
		check(flash_u.mem[0], 8'h99);
		apb(1'b0, ADDR_OPT0, 32'h0, 32'h99, 1'b0);
		apb(1'b1, ADDR_TRIM, 32'h000000a9, 32'h0, 1'b0);
		check(flash_u.mem[14'h2020], 8'ha9);
		apb(1'b0, ADDR_TRIM, 32'h0, 32'ha9, 1'b0);
		apb(1'b0, ADDR_OPT0, 32'h0, 32'h99, 1'b0);
		check(cfg_vec(), exp_cfg(8'hb9, 8'hff, 8'hab, 1'b1));
		apb(1'b0, ADDR_STATUS, 32'h0, 32'h5, 1'b0);
		ev_chk(1'b1, 0, 1);
		ev_chk(1'b0, 0, 1);
		wrap_up();
	end
endmodule
`default_nettype wire
